// ===== design/sbl_link_target.sv
// Target end of the byte handshake link
//
// Contract
// - Link reset aborts everything, releases bus
// - Reset during write may corrupt data
// - Select plus own address bit selects target
// - Busy stays asserted while link owned
// - Phase line high for command or status
// - Direction line high toward the initiator
// - One request per eight-bit byte
// - Request held until acknowledge seen
// - Message line raised after status byte
// - Message phase requests one ending byte
// - Ending handshake releases lines, returns idle
// - Eight bidirectional byte lines, bit 7 MSB
// - No parity on the byte lines
`timescale 1ns/1ps
`default_nettype none

`include "sbl_params.svh"

module sbl_link_target
  import sbl_pkg::*;
#(
  parameter int FIFO_DEPTH = `SBL_FIFO_DEPTH,
  parameter int SYNC_STAGES = `SBL_SYNC_STAGES,
  parameter logic [7:0] END_BYTE = `SBL_END_BYTE
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Link pins from the initiator
  input wire sbl_link_in_t link_in,
  // Link pins toward the initiator
  output sbl_link_out_t link_out,
  // Byte steps from the controller core
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire sbl_cmd_t cmd_in,
  // Received bytes toward the controller core
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic [7:0] rx_data_out,
  // Operation end pulse
  output logic done_out
);

  localparam int LINK_W = $bits(sbl_link_in_t);

  sbl_state_t state_ff;
  sbl_op_t op_ff;
  sbl_link_out_t link_ff;
  logic cmd_ready_ff;
  logic done_ff;
  sbl_link_in_t link_s;
  logic fifo_in_ready;
  logic fifo_push;

  // no parity: byte lines are plain 8-bit data
  function automatic logic is_tx(input sbl_op_t op);
    return (op == SBL_OP_DATA_TX) || (op == SBL_OP_STAT_TX) || (op == SBL_OP_MSG_TX);
  endfunction

  function automatic logic is_ctrl(input sbl_op_t op);
    return (op == SBL_OP_CMD_RX) || (op == SBL_OP_STAT_TX) || (op == SBL_OP_MSG_TX);
  endfunction

  // pulse of 20 cycles always passes two stages
  sbl_sync #(
    .W(LINK_W),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .d_in(link_in),
    .q_out(link_s)
  );

  assign fifo_push = (state_ff == SBL_S_REQ) && link_ff.req && link_s.ack && !is_tx(op_ff);

  // eight byte lines, bit 7 most significant
  sbl_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(link_s.db),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in),
    .out_data_out(rx_data_out)
  );

  // Sequencer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= SBL_S_IDLE;
      op_ff <= SBL_OP_CMD_RX;
      link_ff <= '0;
      cmd_ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (link_s.rst) begin
      // a write cut short is not protected
      state_ff <= SBL_S_IDLE;
      link_ff <= '0;
      cmd_ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        SBL_S_IDLE: begin
          if (link_s.sel && link_s.db[`SBL_ADDR_BIT]) begin
            link_ff.bsy <= 1'b1;
            state_ff <= SBL_S_SEL;
          end
        end
        SBL_S_SEL: begin
          if (!link_s.sel) begin
            cmd_ready_ff <= 1'b1;
            state_ff <= SBL_S_PHASE;
          end
        end
        SBL_S_PHASE: begin
          if (cmd_valid_in && cmd_ready_ff) begin
            cmd_ready_ff <= 1'b0;
            op_ff <= cmd_in.op;
            link_ff.cd <= is_ctrl(cmd_in.op);
            link_ff.io <= is_tx(cmd_in.op);
            link_ff.db <= cmd_in.data;
            link_ff.db_oe <= is_tx(cmd_in.op);
            state_ff <= SBL_S_REQ;
          end
        end
        SBL_S_REQ: begin
          if (!link_ff.req) begin
            if (is_tx(op_ff) || fifo_in_ready) begin
              link_ff.req <= 1'b1;
            end
          end else if (link_s.ack) begin
            link_ff.req <= 1'b0;
            state_ff <= SBL_S_REL;
          end
        end
        SBL_S_REL: begin
          if (!link_s.ack) begin
            link_ff.db_oe <= 1'b0;
            if (op_ff == SBL_OP_STAT_TX) begin
              op_ff <= SBL_OP_MSG_TX;
              link_ff.msg <= 1'b1;
              link_ff.cd <= 1'b1;
              link_ff.io <= 1'b1;
              link_ff.db <= END_BYTE;
              link_ff.db_oe <= 1'b1;
              state_ff <= SBL_S_REQ;
            end else if (op_ff == SBL_OP_MSG_TX) begin
              link_ff <= '0;
              done_ff <= 1'b1;
              state_ff <= SBL_S_IDLE;
            end else begin
              cmd_ready_ff <= 1'b1;
              state_ff <= SBL_S_PHASE;
            end
          end
        end
        // Unused codes fall back to idle
        default: begin
          state_ff <= SBL_S_IDLE;
        end
      endcase
    end
  end

  assign link_out = link_ff;
  assign cmd_ready_out = cmd_ready_ff;
  assign done_out = done_ff;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  link_reset_a: assert property (
    link_s.rst |=> (state_ff == SBL_S_IDLE) && !link_ff.bsy && !link_ff.req && !link_ff.db_oe)
    else $error("link reset did not release the bus");

  sel_busy_a: assert property (
    (state_ff == SBL_S_IDLE) && link_s.sel && link_s.db[`SBL_ADDR_BIT] && !link_s.rst
    |=> link_ff.bsy && (state_ff == SBL_S_SEL))
    else $error("selection did not raise busy");

  busy_hold_a: assert property (
    (state_ff != SBL_S_IDLE) && !link_s.rst |-> link_ff.bsy)
    else $error("busy dropped while link owned");

  cd_phase_a: assert property (
    link_ff.req |-> link_ff.cd == is_ctrl(op_ff))
    else $error("phase line wrong during request");

  io_dir_a: assert property (
    link_ff.req |-> link_ff.io == is_tx(op_ff))
    else $error("direction line wrong during request");

  rx_push_a: assert property (
    $fell(link_ff.req) && !link_ff.io && !$past(link_s.rst) |-> $past(fifo_push))
    else $error("received request did not store exactly one byte");

  req_hold_a: assert property (
    link_ff.req && !link_s.ack && !link_s.rst |=> link_ff.req)
    else $error("request withdrawn before acknowledge");

  req_drop_a: assert property (
    (state_ff == SBL_S_REQ) && link_ff.req && link_s.ack && !link_s.rst
    |=> !link_ff.req ##0 (state_ff == SBL_S_REL))
    else $error("request not withdrawn after acknowledge");

  msg_phase_a: assert property (
    (state_ff == SBL_S_REL) && (op_ff == SBL_OP_STAT_TX) && !link_s.ack && !link_s.rst
    |=> link_ff.msg && link_ff.cd && link_ff.io && (link_ff.db == END_BYTE))
    else $error("message phase not entered after status");

  end_release_a: assert property (
    (state_ff == SBL_S_REL) && link_ff.msg && !link_s.ack && !link_s.rst
    |=> (link_ff == '0) && done_ff ##1 !done_ff)
    else $error("lines not released at operation end");

  db_drive_a: assert property (
    link_ff.db_oe |-> link_ff.bsy && link_ff.io)
    else $error("byte lines driven while not sending");

  sel_drop_a: assert property (
    (state_ff == SBL_S_SEL) && !link_s.sel && !link_s.rst
    |=> (state_ff == SBL_S_PHASE) && cmd_ready_ff)
    else $error("select drop did not open the first step");

  step_take_a: assert property (
    cmd_ready_ff |-> (state_ff == SBL_S_PHASE) && link_ff.bsy && !link_ff.req)
    else $error("step offered outside an owned phase");

  req_once_a: assert property (
    (state_ff != SBL_S_REQ) |-> !link_ff.req)
    else $error("request raised outside a byte step");

  rx_full_a: assert property (
    (state_ff == SBL_S_REQ) && !link_ff.req && !is_tx(op_ff) && !fifo_in_ready
    |=> !link_ff.req)
    else $error("request raised with the buffer full");

  msg_only_a: assert property (
    link_ff.msg |-> (op_ff == SBL_OP_MSG_TX) && link_ff.bsy)
    else $error("message line outside the closing phase");

  end_byte_a: assert property (
    link_ff.msg && link_ff.req |-> link_ff.db_oe && (link_ff.db == END_BYTE))
    else $error("closing request without the ending byte");

  idle_quiet_a: assert property (
    (state_ff == SBL_S_IDLE)
    |-> !link_ff.bsy && !link_ff.req && !link_ff.msg && !link_ff.db_oe && !cmd_ready_ff)
    else $error("lines driven while idle");

  sel_seen_c: cover property (
    (state_ff == SBL_S_SEL) ##[1:20] (state_ff == SBL_S_PHASE));
  rx_byte_c: cover property (fifo_push && (op_ff == SBL_OP_DATA_RX));
  op_end_c: cover property (done_ff);
  abort_c: cover property (link_s.rst && (state_ff == SBL_S_REQ));
  msg_byte_c: cover property (link_ff.msg && link_ff.req);

endmodule

`default_nettype wire

// ===== design/sbl_params.svh
// Constants of the byte handshake link target
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

// Parallel byte lines
`define SBL_DB_W 8
`define SBL_ADDR_BIT 0
`define SBL_DB_RESET 8'h00

// Closing message byte sent after the status byte
`define SBL_END_BYTE 8'h00

// Buffer and synchroniser shape
`define SBL_FIFO_DEPTH 16
`define SBL_SYNC_STAGES 2

// Timing
`define SBL_CLK_NS 50
`define SBL_RST_MIN_NS 1000
`define SBL_RST_MIN_CYC ((`SBL_RST_MIN_NS + `SBL_CLK_NS - 1) / `SBL_CLK_NS)

`endif

// ===== design/sbl_pkg.sv
// Types of the byte handshake link target
package sbl_pkg;

  typedef enum logic [2:0] {
    SBL_OP_CMD_RX  = 3'h0,
    SBL_OP_DATA_RX = 3'h1,
    SBL_OP_DATA_TX = 3'h2,
    SBL_OP_STAT_TX = 3'h3,
    SBL_OP_MSG_TX  = 3'h4
  } sbl_op_t;

  typedef enum logic [2:0] {
    SBL_S_IDLE  = 3'h0,
    SBL_S_SEL   = 3'h1,
    SBL_S_PHASE = 3'h2,
    SBL_S_REQ   = 3'h3,
    SBL_S_REL   = 3'h4
  } sbl_state_t;

  // One byte step asked by the controller core
  typedef struct packed {
    sbl_op_t op;
    logic [7:0] data;
  } sbl_cmd_t;

  // Lines driven by the initiator
  typedef struct packed {
    logic rst;
    logic sel;
    logic ack;
    logic [7:0] db;
  } sbl_link_in_t;

  // Lines driven by this target
  typedef struct packed {
    logic bsy;
    logic cd;
    logic io;
    logic req;
    logic msg;
    logic [7:0] db;
    logic db_oe;
  } sbl_link_out_t;

endpackage

// ===== design/sbl_sync.sv
// Multi-stage synchroniser for link inputs
`timescale 1ns/1ps
`default_nettype none

module sbl_sync #(
  parameter int W = 1,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] st_ff [STAGES];

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < STAGES; i++) begin
        st_ff[i] <= '0;
      end
    end else begin
      st_ff[0] <= d_in;
      for (int i = 1; i < STAGES; i++) begin
        st_ff[i] <= st_ff[i-1];
      end
    end
  end

  assign q_out = st_ff[STAGES-1];

endmodule

`default_nettype wire

// ===== design/sbl_fifo.sv
// Byte FIFO with registered full and empty flags
`timescale 1ns/1ps
`default_nettype none

module sbl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic full_ff;
  logic empty_ff;
  logic valid_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_cnt;

  assign push = in_valid_in && !full_ff;
  assign pop = out_ready_in && !empty_ff;
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == (AW+1)'(DEPTH));
      empty_ff <= (nxt_cnt == '0);
      valid_ff <= (nxt_cnt != '0);
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ff] <= in_data_in;
    end
  end

  assign in_ready_out = !full_ff;
  assign out_valid_out = valid_ff;
  assign out_data_out = mem[rd_ff];

endmodule

`default_nettype wire

// ===== test/sbl_initiator.sv
// Behavioural initiator that drives the target's link pins
`timescale 1ns/1ps
`default_nettype none

module sbl_initiator
  import sbl_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Target lines and resolved byte wire
  input wire sbl_link_out_t tgt_in,
  input wire logic [7:0] wire_db_in,
  // Initiator lines
  output sbl_link_in_t ini_out,
  output logic db_oe_out
);
  initial begin
    ini_out = '0;
    db_oe_out = 1'b0;
  end

  task automatic link_reset();
    @(negedge clk_in);
    ini_out.rst = 1'b1;
    repeat (24) @(negedge clk_in);
    ini_out.rst = 1'b0;
  endtask

  // select with address bit, drop on busy
  task automatic select(input logic addr, output logic won);
    won = 1'b0;
    @(negedge clk_in);
    ini_out.db = {7'h2a, addr};
    db_oe_out = 1'b1;
    ini_out.sel = 1'b1;
    for (int i = 0; i < 10 && !won; i++) begin
      @(negedge clk_in);
      won = tgt_in.bsy;
    end
    ini_out.sel = 1'b0;
    db_oe_out = 1'b0;
  endtask

  // one byte per request, ack held until request drops
  task automatic xfer(input logic [7:0] send, input int slow, output logic [7:0] got,
                      output logic [5:0] ph);
    ph = '0;
    got = 8'h00;
    for (int i = 0; i < 300 && tgt_in.req !== 1'b1; i++) @(negedge clk_in);
    if (tgt_in.req !== 1'b1) return;
    ph = {tgt_in.req, tgt_in.bsy, tgt_in.cd, tgt_in.io, tgt_in.msg, tgt_in.db_oe};
    got = wire_db_in;
    if (!tgt_in.io) begin
      ini_out.db = send;
      db_oe_out = 1'b1;
    end
    repeat (slow + 1) @(negedge clk_in);
    ini_out.ack = 1'b1;
    for (int i = 0; i < 20 && tgt_in.req === 1'b1; i++) @(negedge clk_in);
    ini_out.ack = 1'b0;
    db_oe_out = 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== test/tb_sbl_link_target.sv
// Testbench of the byte handshake link target
`timescale 1ns/1ps
`default_nettype none

`include "sbl_params.svh"

module tb_sbl_link_target
  import sbl_pkg::*;
;
  logic clk_in = 1'b0;
  logic arst_n_in;
  sbl_link_in_t link_in;
  sbl_link_in_t ini_pins;
  sbl_link_out_t link_out;
  logic ini_oe, cmd_valid_in, cmd_ready_out, rx_valid_out, rx_ready_in, done_out, won;
  sbl_cmd_t cmd_in;
  logic [7:0] rx_data_out, db_wire, got;
  logic [7:0] last_db = 8'h00;
  logic [5:0] ph;
  logic [7:0] exp_q[$];
  integer seed, bad_count = 0, num_checks = 0, dones = 0;

  always #25 clk_in = ~clk_in;

  // Released wire shows the inverse of its last value
  assign db_wire = link_out.db_oe ? link_out.db : ini_oe ? ini_pins.db : ~last_db;
  assign link_in = '{rst: ini_pins.rst, sel: ini_pins.sel, ack: ini_pins.ack, db: db_wire};
  always @(posedge clk_in) begin
    if (link_out.db_oe || ini_oe) last_db <= db_wire;
  end
  always @(negedge clk_in) begin
    if (done_out === 1'b1) dones++;
  end

  sbl_link_target u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .link_in(link_in),
    .link_out(link_out), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
    .cmd_in(cmd_in), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
    .rx_data_out(rx_data_out), .done_out(done_out));
  sbl_initiator u_ini (.clk_in(clk_in), .tgt_in(link_out), .wire_db_in(db_wire),
    .ini_out(ini_pins), .db_oe_out(ini_oe));

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic core_step(input sbl_op_t op, input logic [7:0] d);
    @(negedge clk_in);
    cmd_in = '{op: op, data: d};
    cmd_valid_in = 1'b1;
    for (int i = 0; i < 400 && cmd_ready_out !== 1'b1; i++) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
  endtask

  task automatic rx_byte(input sbl_op_t op);
    logic [7:0] d;
    d = 8'($random(seed));
    fork
      core_step(op, 8'h00);
      u_ini.xfer(d, $random(seed) & 3, got, ph);
    join
    exp_q.push_back(d);
    chk(ph === {3'b110 | {2'b00, op == SBL_OP_CMD_RX}, 3'b000}, "rx phase lines");
  endtask

  task automatic tx_byte(input sbl_op_t op, input logic [7:0] d, input logic [5:0] phx);
    fork
      core_step(op, d);
      u_ini.xfer(8'h00, $random(seed) & 3, got, ph);
    join
    chk(got === d && ph === phx, "tx byte or phase");
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) begin
      @(negedge clk_in);
      if (rx_ready_in) rx_ready_in = 1'b0;
      else if (rx_valid_out === 1'b1 && $random(seed) % 3 != 0) begin
        chk(rx_data_out === exp_q.pop_front(), "received byte");
        rx_ready_in = 1'b1;
      end
    end
    @(negedge clk_in);
    rx_ready_in = 1'b0;
  endtask

  initial begin
    seed = 10;
    arst_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    rx_ready_in = 1'b0;
    repeat (5) @(negedge clk_in);
    arst_n_in = 1'b1;
    chk(link_out === '0 && rx_valid_out === 1'b0, "reset state");
    u_ini.select(1'b0, won);
    chk(won === 1'b0, "select without address");
    u_ini.select(1'b1, won);
    chk(won === 1'b1, "no busy on select");
    for (int i = 0; i < 6; i++) rx_byte(SBL_OP_CMD_RX);
    drain();
    for (int i = 0; i < 16; i++) rx_byte(SBL_OP_DATA_RX);
    fork
      rx_byte(SBL_OP_DATA_RX);
      begin
        repeat (30) @(negedge clk_in);
        chk(link_out.req === 1'b0, "request with full buffer");
        drain();
      end
    join
    drain();
    chk(rx_valid_out === 1'b0, "buffer not empty");
    for (int i = 0; i < 4; i++) tx_byte(SBL_OP_DATA_TX, 8'($random(seed)), 6'b110101);
    tx_byte(SBL_OP_STAT_TX, 8'($random(seed)), 6'b111101);
    u_ini.xfer(8'h00, 1, got, ph);
    chk(got === `SBL_END_BYTE && ph === 6'b111111, "closing byte");
    repeat (6) @(negedge clk_in);
    chk(link_out === '0 && dones == 1, "release after closing byte");
    u_ini.select(1'b1, won);
    fork
      core_step(SBL_OP_DATA_TX, 8'ha5);
      begin
        for (int i = 0; i < 50 && link_out.req !== 1'b1; i++) @(negedge clk_in);
        u_ini.link_reset();
      end
    join
    repeat (4) @(negedge clk_in);
    chk(link_out === '0 && dones == 1, "abort on link reset");
    complete_run();
  end

  initial begin
    #(10000 * 50);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule

`default_nettype wire
